// ==== test/host_reg_model.sv ====
// Host-side register master model driving the flat register port.
`timescale 1ns/100ps
`default_nettype none
module host_reg_model (
	input wire logic core_clk,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid
);
	// Idle bus until the first access.
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// One strobe cycle per access; released lines show the inverse so stale values never help.
	task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data,
		output logic [7:0] rdata, output logic ok);
		@(negedge core_clk);
		reg_addr = addr;
		reg_wdata = data;
		reg_wr = wr;
		reg_rd = !wr;
		@(negedge core_clk);
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = ~addr;
		reg_wdata = ~data;
		rdata = reg_rdata;
		ok = wr || (reg_rvalid === 1'b1);
	endtask
endmodule
`default_nettype wire

// ==== test/test_pmic_event_sense_mask.sv ====
// Self-checking bench for the event sense, latch and interrupt gate block.
`timescale 1ns/100ps
`default_nettype none
module test_pmic_event_sense_mask;
	import pmic_pkg::*;
	logic core_clk, nrst, thermal_restart, reg_wr, reg_rd, reg_rvalid, irq;
	logic [7:0] live [2];
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [1:0] sel;
	int n_errors = 0;
	int check_count = 0;

	pmic_event_sense_mask dut_u (.core_clk(core_clk), .nrst(nrst),
		.buck_output_good_live(live[0][0]), .linreg_output_good_live(live[0][4:1]),
		.ext_clock_valid_live(live[0][6]), .running_on_ext_clock_live(live[0][7]),
		.buck_overcurrent_live(live[1][0]), .linreg_overcurrent_live(live[1][4:1]),
		.input_undervoltage_live(live[1][5]), .thermal_warning_live(live[1][6]),
		.thermal_shutdown_live(live[1][7]), .thermal_restart(thermal_restart),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .irq(irq),
		.post_shutdown_restart_sel(sel));

	host_reg_model host_u (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

	// Free-running core clock.
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	task automatic summarize();
		$display("Errors %0d, checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
		logic [7:0] d;
		logic ok;
		host_u.access(1'b0, addr, 8'h00, d, ok);
		chk({7'h00, ok}, 8'h01);
		chk(d, exp);
	endtask

	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		logic [7:0] d;
		logic ok;
		host_u.access(1'b1, addr, data, d, ok);
	endtask

	// Synchroniser plus edge compare plus irq register all fit in five cycles.
	task automatic settle();
		repeat (5) @(negedge core_clk);
	endtask

	task automatic t_defaults();
		rd(ADDR_GATE_POWER_CLOCK, GATE_RESET);
		rd(ADDR_GATE_FAULT, GATE_RESET);
		rd(ADDR_RESET_CONTROL, RESET_CONTROL_RESET);
		rd(ADDR_LIVE_POWER_CLOCK, 8'h00);
		rd(ADDR_LIVE_FAULT, 8'h00);
		rd(ADDR_LATCH_POWER_CLOCK, LATCH_RESET);
		rd(8'h40, READ_UNMAPPED);
		chk({7'h00, irq}, 8'h00);
	endtask

	// Walk every source through a rise and a fall; all gates are set so irq stays low.
	task automatic t_sense();
		for (int b = 0; b < 2; b++) begin
			for (int k = 0; k < 8; k++) begin
				if (b == 0 && k == 5) begin
					continue;
				end
				@(negedge core_clk);
				live[b][k] = 1'b1;
				settle();
				wr(ADDR_LIVE_POWER_CLOCK + 8'(b), 8'h00);
				rd(ADDR_LIVE_POWER_CLOCK + 8'(b), 8'(1 << k));
				rd(ADDR_LATCH_POWER_CLOCK + 8'(b), 8'(1 << k));
				rd(ADDR_LATCH_POWER_CLOCK + 8'(b), 8'h00);
				live[b][k] = 1'b0;
				settle();
				rd(ADDR_LIVE_POWER_CLOCK + 8'(b), 8'h00);
				rd(ADDR_LATCH_POWER_CLOCK + 8'(b), 8'(1 << k));
				chk({7'h00, irq}, 8'h00);
			end
		end
	endtask

	task automatic t_gate();
		wr(ADDR_GATE_POWER_CLOCK, 8'h00);
		rd(ADDR_GATE_POWER_CLOCK, 8'h20);
		wr(ADDR_GATE_FAULT, 8'hbf);
		live[1][6] = 1'b1;
		settle();
		chk({7'h00, irq}, 8'h01);
		wr(ADDR_GATE_FAULT, 8'hff);
		repeat (2) @(negedge core_clk);
		chk({7'h00, irq}, 8'h00);
		wr(ADDR_GATE_FAULT, 8'hbf);
		repeat (2) @(negedge core_clk);
		chk({7'h00, irq}, 8'h01);
		rd(ADDR_LATCH_FAULT, 8'h40);
		repeat (2) @(negedge core_clk);
		chk({7'h00, irq}, 8'h00);
		live[1][6] = 1'b0;
		settle();
		chk({7'h00, irq}, 8'h01);
		rd(ADDR_LATCH_FAULT, 8'h40);
		wr(ADDR_GATE_FAULT, 8'hff);
	endtask

	// Restart field codes, refused code 11, restart pulse and forced defaults.
	task automatic t_reset();
		wr(ADDR_RESET_CONTROL, 8'h02);
		rd(ADDR_RESET_CONTROL, 8'h02);
		chk({6'h00, sel}, 8'h02);
		wr(ADDR_RESET_CONTROL, 8'h13);
		rd(ADDR_RESET_CONTROL, 8'h12);
		wr(ADDR_RESET_CONTROL, 8'h01);
		wr(ADDR_GATE_FAULT, 8'h5a);
		@(negedge core_clk);
		thermal_restart = 1'b1;
		@(negedge core_clk);
		thermal_restart = 1'b0;
		rd(ADDR_RESET_CONTROL, 8'h01);
		rd(ADDR_GATE_FAULT, 8'h5a);
		wr(ADDR_RESET_CONTROL, 8'h00);
		wr(ADDR_GATE_FAULT, 8'h0f);
		@(negedge core_clk);
		thermal_restart = 1'b1;
		@(negedge core_clk);
		thermal_restart = 1'b0;
		rd(ADDR_GATE_FAULT, GATE_RESET);
		rd(ADDR_RESET_CONTROL, RESET_CONTROL_RESET);
		chk({6'h00, sel}, 8'h00);
		wr(ADDR_GATE_FAULT, 8'h00);
		wr(ADDR_RESET_CONTROL, 8'h02);
		wr(ADDR_RESET_CONTROL, 8'h80);
		rd(ADDR_GATE_FAULT, GATE_RESET);
		rd(ADDR_GATE_POWER_CLOCK, GATE_RESET);
		rd(ADDR_RESET_CONTROL, RESET_CONTROL_RESET);
	endtask

	// Forced defaults drop a latched event; a mid-run reset with a source high makes a new one.
	task automatic t_midreset();
		live[0][0] = 1'b1;
		settle();
		wr(ADDR_GATE_POWER_CLOCK, 8'h00);
		repeat (2) @(negedge core_clk);
		chk({7'h00, irq}, 8'h01);
		wr(ADDR_RESET_CONTROL, 8'h80);
		repeat (2) @(negedge core_clk);
		chk({7'h00, irq}, 8'h00);
		rd(ADDR_LATCH_POWER_CLOCK, LATCH_RESET);
		nrst = 1'b0;
		@(negedge core_clk);
		chk({reg_rvalid, irq, sel, 4'h0}, 8'h00);
		chk(reg_rdata, 8'h00);
		repeat (2) @(negedge core_clk);
		nrst = 1'b1;
		settle();
		rd(ADDR_LIVE_POWER_CLOCK, 8'h01);
		rd(ADDR_LATCH_POWER_CLOCK, 8'h01);
		chk({7'h00, irq}, 8'h00);
		live[0][0] = 1'b0;
		settle();
		rd(ADDR_LATCH_POWER_CLOCK, 8'h01);
	endtask

	// Main sequence; all live inputs start low so reset creates no events.
	initial begin
		nrst = 1'b0;
		thermal_restart = 1'b0;
		live[0] = 8'h00;
		live[1] = 8'h00;
		repeat (12) @(negedge core_clk);
		nrst = 1'b1;
		t_defaults();
		t_sense();
		t_gate();
		t_reset();
		t_midreset();
		summarize();
	end

	// Watchdog well beyond the roughly five hundred cycles the tests need.
	initial begin
		#60000;
		n_errors++;
		summarize();
	end
endmodule
`default_nettype wire

// ==== verilog/event_bank.sv ====
// One bank of eight sense synchronisers with dual-edge event latches.
`timescale 1ns/100ps
`default_nettype none
module event_bank
	import pmic_pkg::*;
(
	input wire logic core_clk,
	input wire logic nrst,
	event_bank_if.bank bus
);
	logic [7:0] meta_q;
	logic [7:0] sense_q;
	logic [7:0] prev_q;
	logic [7:0] ack_q;
	logic [7:0] change;

	// Comparator conditions come from analog circuits, so two flops come first.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			meta_q <= LATCH_RESET;
			sense_q <= LATCH_RESET;
			prev_q <= LATCH_RESET;
		end else begin
			meta_q <= bus.raw;
			sense_q <= meta_q;
			prev_q <= sense_q;
		end
	end

	// Either direction of change counts as an event.
	assign change = sense_q ^ prev_q; // R10

	// A change in the clearing cycle wins, so no event is lost to a read.
	generate
		for (genvar i = 0; i < 8; i++) begin : g_latch
			always_ff @(posedge core_clk or negedge nrst) begin
				if (!nrst) begin
					ack_q[i] <= 1'b0;
				end else if (change[i]) begin
					ack_q[i] <= 1'b1; // R10
				end else if (bus.clear[i] || bus.clear_all) begin
					ack_q[i] <= 1'b0; // R10
				end
			end
		end
	endgenerate

	assign bus.sense = sense_q;
	assign bus.ack = ack_q;
	// Only latched events whose gate bit is cleared reach the interrupt.
	assign bus.pending = |(ack_q & ~bus.mask); // R8

	property p_latch_on_change;
		@(posedge core_clk) disable iff (!nrst)
		(change != 8'h00) |=> ((ack_q & $past(change)) == $past(change));
	endproperty
	a_latch_on_change: assert property (p_latch_on_change) else $error("event not latched"); // R10

	property p_clear_on_read;
		@(posedge core_clk) disable iff (!nrst)
		(bus.clear == ALL_BITS && change == 8'h00) |=> (ack_q == 8'h00);
	endproperty
	a_clear_on_read: assert property (p_clear_on_read) else $error("latch not cleared"); // R10
endmodule
`default_nettype wire

// ==== verilog/event_bank_if.sv ====
// Signals shared between the register logic and one bank of event latches.
`timescale 1ns/100ps
`default_nettype none
interface event_bank_if;
	logic [7:0] raw;
	logic [7:0] sense;
	logic [7:0] mask;
	logic [7:0] clear;
	logic clear_all;
	logic [7:0] ack;
	logic pending;

	modport bank (input raw, input mask, input clear, input clear_all,
		output sense, output ack, output pending);
	modport ctrl (output raw, output mask, output clear, output clear_all,
		input sense, input ack, input pending);
endinterface
`default_nettype wire

// ==== verilog/pmic_event_sense_mask.sv ====
// Sense, event latch, interrupt gate and reset-control registers of the power chip.
// Operation
// [R1] Power-good bits: buck bit 0, linregs 1-4.
// [R2] External clock valid reads one when in window.
// [R3] Bit 7 reads one on external clock.
// [R4] Overcurrent bits: buck bit 0, linregs 1-4.
// [R5] Undervoltage bit reads one below lockout threshold.
// [R6] Thermal warning bit reads one above limit.
// [R7] Thermal shutdown bit 7 reads one above limit.
// [R8] Cleared gate bit enables source, set blocks.
// [R9] Gate spare bit holds one, sense spare zero.
// [R10] Latch any edge of sense; clear on read.
// [R11] Force bit restores all register defaults, reads zero.
// [R12] Two-bit field picks behaviour after thermal shutdown.
// [R13] Interrupt while any ungated latched event remains.
// [R14] Sense registers ignore writes and follow conditions.
`timescale 1ns/100ps
`default_nettype none
module pmic_event_sense_mask
	import pmic_pkg::*;
(
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic buck_output_good_live,
	input wire logic [3:0] linreg_output_good_live,
	input wire logic ext_clock_valid_live,
	input wire logic running_on_ext_clock_live,
	input wire logic buck_overcurrent_live,
	input wire logic [3:0] linreg_overcurrent_live,
	input wire logic input_undervoltage_live,
	input wire logic thermal_warning_live,
	input wire logic thermal_shutdown_live,
	input wire logic thermal_restart,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	output logic irq,
	output logic [1:0] post_shutdown_restart_sel
);
	logic [7:0] gate_power_clock_q;
	logic [7:0] gate_fault_q;
	logic defaults_loaded_flag_q;
	logic [1:0] rearm_q;
	logic [7:0] rdata_q;
	logic rvalid_q;
	logic irq_q;
	logic [7:0] rdata_d;
	logic force_write;
	logic restore_defaults;
	logic wr_gate_power_clock;
	logic wr_gate_fault;
	logic wr_reset_control;

	event_bank_if bank_bus[BANK_COUNT] ();

	// Bank 0 gathers power-good and clock conditions; its spare input is tied low.
	assign bank_bus[0].raw = {running_on_ext_clock_live, // R3
		ext_clock_valid_live, // R2
		1'b0, // R9
		linreg_output_good_live, // R1
		buck_output_good_live}; // R1

	// Bank 1 gathers overcurrent, undervoltage and thermal conditions.
	assign bank_bus[1].raw = {thermal_shutdown_live, // R7
		thermal_warning_live, // R6
		input_undervoltage_live, // R5
		linreg_overcurrent_live, // R4
		buck_overcurrent_live}; // R4

	// Gate registers feed each bank so that its pending term is already masked.
	assign bank_bus[0].mask = gate_power_clock_q; // R8
	assign bank_bus[1].mask = gate_fault_q; // R8

	// A read of a latch register clears every bit that was returned.
	assign bank_bus[0].clear = (reg_rd && reg_addr == ADDR_LATCH_POWER_CLOCK) ? ALL_BITS : 8'h00; // R10
	assign bank_bus[1].clear = (reg_rd && reg_addr == ADDR_LATCH_FAULT) ? ALL_BITS : 8'h00; // R10

	generate
		for (genvar g = 0; g < BANK_COUNT; g++) begin : g_bank
			assign bank_bus[g].clear_all = restore_defaults; // R11
			event_bank u_bank (
				.core_clk(core_clk),
				.nrst(nrst),
				.bus(bank_bus[g])
			);
		end
	endgenerate

	// Write decode; sense and latch addresses have no write path at all.
	assign wr_gate_power_clock = reg_wr && reg_addr == ADDR_GATE_POWER_CLOCK;
	assign wr_gate_fault = reg_wr && reg_addr == ADDR_GATE_FAULT;
	assign wr_reset_control = reg_wr && reg_addr == ADDR_RESET_CONTROL;
	assign force_write = wr_reset_control && reg_wdata[BIT_FORCE_DEFAULTS];

	// A forced reset, or a shutdown restart that asks for defaults, reloads everything.
	assign restore_defaults = force_write ||
		(thermal_restart && rearm_q == REARM_RESTART_DEFAULTS); // R11 R12

	// Gate for power and clock events; the spare bit is not writable.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			gate_power_clock_q <= GATE_RESET;
		end else if (restore_defaults) begin
			gate_power_clock_q <= GATE_RESET; // R11
		end else if (wr_gate_power_clock) begin
			gate_power_clock_q <= reg_wdata;
			gate_power_clock_q[BIT_POWER_CLOCK_SPARE] <= 1'b1; // R9
		end
	end

	// Gate for fault events.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			gate_fault_q <= GATE_RESET;
		end else if (restore_defaults) begin
			gate_fault_q <= GATE_RESET; // R11
		end else if (wr_gate_fault) begin
			gate_fault_q <= reg_wdata;
		end
	end

	// Defaults-loaded flag is set by any reload and cleared by software writing zero.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			defaults_loaded_flag_q <= RESET_CONTROL_RESET[BIT_DEFAULTS_LOADED];
		end else if (restore_defaults) begin
			defaults_loaded_flag_q <= RESET_CONTROL_RESET[BIT_DEFAULTS_LOADED]; // R11
		end else if (wr_reset_control) begin
			defaults_loaded_flag_q <= reg_wdata[BIT_DEFAULTS_LOADED];
		end
	end

	// Restart selection; the reserved code is refused and the old choice kept,
	// because the shutdown logic has no defined meaning for it.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rearm_q <= RESET_CONTROL_RESET[REARM_LSB +: 2];
		end else if (restore_defaults) begin
			rearm_q <= RESET_CONTROL_RESET[REARM_LSB +: 2]; // R11
		end else if (wr_reset_control && reg_wdata[REARM_LSB +: 2] != REARM_ILLEGAL) begin
			rearm_q <= reg_wdata[REARM_LSB +: 2]; // R12
		end
	end

	// Read mux; sense values come straight from the synchronisers, never latched.
	always_comb begin
		rdata_d = READ_UNMAPPED;
		case (reg_addr)
			ADDR_LATCH_POWER_CLOCK: begin
				rdata_d = bank_bus[0].ack & ~(8'h01 << BIT_POWER_CLOCK_SPARE); // R9
			end
			ADDR_LATCH_FAULT: begin
				rdata_d = bank_bus[1].ack;
			end
			ADDR_LIVE_POWER_CLOCK: begin
				rdata_d = bank_bus[0].sense; // R14
			end
			ADDR_LIVE_FAULT: begin
				rdata_d = bank_bus[1].sense; // R14
			end
			ADDR_GATE_POWER_CLOCK: begin
				rdata_d = gate_power_clock_q;
			end
			ADDR_GATE_FAULT: begin
				rdata_d = gate_fault_q;
			end
			ADDR_RESET_CONTROL: begin
				// The force bit is a one-shot and always reads back as zero.
				rdata_d = 8'h00;
				rdata_d[BIT_DEFAULTS_LOADED] = defaults_loaded_flag_q;
				rdata_d[REARM_LSB +: 2] = rearm_q;
			end
			default: begin
				rdata_d = READ_UNMAPPED;
			end
		endcase
	end

	// Read data is held until the next read so the serial engine may shift it slowly.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= READ_UNMAPPED;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= reg_rd;
			if (reg_rd) begin
				rdata_q <= rdata_d;
			end
		end
	end

	// Interrupt is registered so the pin never glitches on mask writes.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= bank_bus[0].pending || bank_bus[1].pending; // R13
		end
	end

	assign reg_rdata = rdata_q;
	assign reg_rvalid = rvalid_q;
	assign irq = irq_q;
	assign post_shutdown_restart_sel = rearm_q; // R12

	sequence s_force_write;
		force_write;
	endsequence

	sequence s_read_at(logic [7:0] a);
		reg_rd && reg_addr == a;
	endsequence

	property p_irq_raise;
		@(posedge core_clk) disable iff (!nrst)
		(((bank_bus[0].ack & ~gate_power_clock_q) | (bank_bus[1].ack & ~gate_fault_q)) != 8'h00)
		|=> irq_q;
	endproperty
	a_irq_raise: assert property (p_irq_raise) else $error("unmasked event without interrupt"); // R13

	property p_irq_drop;
		@(posedge core_clk) disable iff (!nrst)
		(((bank_bus[0].ack & ~gate_power_clock_q) | (bank_bus[1].ack & ~gate_fault_q)) == 8'h00)
		|=> !irq_q;
	endproperty
	a_irq_drop: assert property (p_irq_drop) else $error("interrupt with no unmasked event"); // R8

	property p_force_defaults;
		@(posedge core_clk) disable iff (!nrst)
		s_force_write |=> (gate_power_clock_q == GATE_RESET && gate_fault_q == GATE_RESET
			&& defaults_loaded_flag_q && rearm_q == REARM_RESTART_DEFAULTS);
	endproperty
	a_force_defaults: assert property (p_force_defaults) else $error("forced reset incomplete"); // R11

	property p_force_reads_zero;
		@(posedge core_clk) disable iff (!nrst)
		s_read_at(ADDR_RESET_CONTROL) |=> (reg_rvalid && !reg_rdata[BIT_FORCE_DEFAULTS]);
	endproperty
	a_force_reads_zero: assert property (p_force_reads_zero) else $error("force bit reads one"); // R11

	property p_gate_spare;
		@(posedge core_clk) disable iff (!nrst)
		gate_power_clock_q[BIT_POWER_CLOCK_SPARE];
	endproperty
	a_gate_spare: assert property (p_gate_spare) else $error("gate spare bit lost"); // R9

	property p_sense_spare;
		@(posedge core_clk) disable iff (!nrst)
		s_read_at(ADDR_LIVE_POWER_CLOCK) |=> (reg_rvalid && !reg_rdata[BIT_POWER_CLOCK_SPARE]);
	endproperty
	a_sense_spare: assert property (p_sense_spare) else $error("sense spare bit reads one"); // R9

	property p_live_power_clock;
		@(posedge core_clk) disable iff (!nrst)
		s_read_at(ADDR_LIVE_POWER_CLOCK) |=> (reg_rdata == $past(bank_bus[0].sense));
	endproperty
	a_live_power_clock: assert property (p_live_power_clock) else $error("sense 1 not live"); // R1

	property p_live_fault;
		@(posedge core_clk) disable iff (!nrst)
		s_read_at(ADDR_LIVE_FAULT) |=> (reg_rdata == $past(bank_bus[1].sense));
	endproperty
	a_live_fault: assert property (p_live_fault) else $error("sense 2 not live"); // R14

	property p_rearm_legal;
		@(posedge core_clk) disable iff (!nrst)
		rearm_q != REARM_ILLEGAL;
	endproperty
	a_rearm_legal: assert property (p_rearm_legal) else $error("reserved restart code held"); // R12

	property p_restart_keeps;
		@(posedge core_clk) disable iff (!nrst)
		(thermal_restart && rearm_q != REARM_RESTART_DEFAULTS && !reg_wr)
		|=> ($stable(gate_power_clock_q) && $stable(gate_fault_q));
	endproperty
	a_restart_keeps: assert property (p_restart_keeps) else $error("restart lost register values"); // R12

	// A plain gate write that no reload overrides.
	sequence s_gate_fault_write;
		reg_wr && reg_addr == ADDR_GATE_FAULT && !restore_defaults;
	endsequence

	property p_gate_write_lands;
		@(posedge core_clk) disable iff (!nrst)
		s_gate_fault_write |=> (gate_fault_q == $past(reg_wdata));
	endproperty
	a_gate_write_lands: assert property (p_gate_write_lands) else $error("gate write lost"); // R8

	property p_rearm_refused;
		@(posedge core_clk) disable iff (!nrst)
		(wr_reset_control && reg_wdata[REARM_LSB +: 2] == REARM_ILLEGAL && !restore_defaults)
		|=> $stable(rearm_q);
	endproperty
	a_rearm_refused: assert property (p_rearm_refused) else $error("reserved restart code taken"); // R12

	property p_restart_defaults;
		@(posedge core_clk) disable iff (!nrst)
		(thermal_restart && rearm_q == REARM_RESTART_DEFAULTS)
		|=> (gate_power_clock_q == GATE_RESET && gate_fault_q == GATE_RESET
			&& defaults_loaded_flag_q);
	endproperty
	a_restart_defaults: assert property (p_restart_defaults) else $error("restart kept values"); // R12

	property p_latch_fault_read;
		@(posedge core_clk) disable iff (!nrst)
		s_read_at(ADDR_LATCH_FAULT) |=> (reg_rvalid && reg_rdata == $past(bank_bus[1].ack));
	endproperty
	a_latch_fault_read: assert property (p_latch_fault_read) else $error("fault latch misread"); // R10

	property p_latch_power_clock_read;
		@(posedge core_clk) disable iff (!nrst)
		s_read_at(ADDR_LATCH_POWER_CLOCK) |=> (!reg_rdata[BIT_POWER_CLOCK_SPARE]
			&& reg_rdata[4:0] == $past(bank_bus[0].ack[4:0]));
	endproperty
	a_latch_power_clock_read: assert property (p_latch_power_clock_read) else $error("latch 1 misread"); // R9
endmodule
`default_nettype wire

// ==== verilog/pmic_pkg.sv ====
// Register map, field positions and reset values of the event sense and mask block.
package pmic_pkg;
	localparam logic [7:0] ADDR_LATCH_POWER_CLOCK = 8'h20;
	localparam logic [7:0] ADDR_LATCH_FAULT = 8'h21;
	localparam logic [7:0] ADDR_LIVE_POWER_CLOCK = 8'h22;
	localparam logic [7:0] ADDR_LIVE_FAULT = 8'h23;
	localparam logic [7:0] ADDR_GATE_POWER_CLOCK = 8'h24;
	localparam logic [7:0] ADDR_GATE_FAULT = 8'h25;
	localparam logic [7:0] ADDR_RESET_CONTROL = 8'h30;

	localparam logic [7:0] LATCH_RESET = 8'h00;
	localparam logic [7:0] GATE_RESET = 8'hff;
	localparam logic [7:0] RESET_CONTROL_RESET = 8'h10;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;
	localparam logic [7:0] ALL_BITS = 8'hff;

	localparam int BIT_FORCE_DEFAULTS = 7;
	localparam int BIT_DEFAULTS_LOADED = 4;
	localparam int REARM_LSB = 0;
	localparam int BIT_POWER_CLOCK_SPARE = 5;
	localparam int BANK_COUNT = 2;

	localparam logic [1:0] REARM_RESTART_DEFAULTS = 2'h0;
	localparam logic [1:0] REARM_RESTART_KEEP = 2'h1;
	localparam logic [1:0] REARM_STAY_OFF = 2'h2;
	localparam logic [1:0] REARM_ILLEGAL = 2'h3;
endpackage
